// File: dv/timer8_prescaler_waveform_control_bench.sv
// Purpose: Self-checking bench for the timer core
// Assumes: Zero-wait APB slave, read data valid at the access edge
// Notes:   Counts are judged within windows since prescaler phase varies
`timescale 1ns/1ps
`default_nettype none
module timer8_prescaler_waveform_control_bench;
  import tmr_pkg::*;
  logic clock, rstn, io_tick, xtal_tick, xin, dir, pready, pslverr, pin, oe_n, ovr, irq, e;
  tmr_apb_req_s req;
  logic [31:0] prdata, r;
  int num_errors = 0;
  int samples_checked = 0;
  int c;
  tmr_core dut (.clock(clock), .rstn(rstn), .clk_en(1'b1), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .io_tick(io_tick), .xtal_tick(xtal_tick),
    .crystal_input_pin(xin), .pin_dir_out(dir), .compare_output_pin(pin),
    .compare_output_oe_n(oe_n), .compare_override(ovr), .irq(irq));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      complete_run();
    end
    e = pslverr;
    r = prdata;
    req <= '0;
    @(posedge clock);
  endtask
  task automatic t_regs();
    xfer(0, OFF_CTRL_A, 0); check(r, 0);
    xfer(1, OFF_CTRL_A, 32'hFF); xfer(0, OFF_CTRL_A, 0); check(r, 32'hC3);
    xfer(1, OFF_CTRL_B, 32'h7A); xfer(0, OFF_CTRL_B, 0); check(r, 32'h02);
    xfer(1, OFF_CTRL_B, 0); xfer(0, 8'h24, 0); check(e, 1);
    $display("test regs done");
  endtask
  task automatic t_force();
    logic [7:0] ca [5] = '{8'h80, 8'h40, 8'h40, 8'hC0, 8'h42};
    dir <= 1'b1;
    // Earlier register test may have let the counter raise flags
    xfer(1, OFF_IRQ_CLEAR, 3);
    for (int k = 0; k < 5; k++) begin
      xfer(1, OFF_CTRL_A, ca[k]); xfer(1, OFF_CTRL_B, 32'h80);
      check(pin, k % 2 == 0 ? 0 : 1);
    end
    check(ovr, 1); check(oe_n, 0);
    xfer(0, OFF_CTRL_B, 0); check(r, 0);
    xfer(0, OFF_IRQ_STATUS, 0); check(r, 0);
    dir <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    check(oe_n, 1);
    dir <= 1'b1;
    xfer(1, OFF_CTRL_A, 32'h43); check(oe_n, 1);
    xfer(1, OFF_CTRL_B, 32'h80); check(pin, 0);
    xfer(1, OFF_CTRL_A, 32'h41); check(oe_n, 1);
    xfer(1, OFF_CTRL_A, 0); check(ovr, 0);
    $display("test force done");
  endtask
  // Overflow from 0xF0 takes 16 divided ticks at each tap
  task automatic t_prescale();
    int n [3] = '{1, 8, 32};
    xfer(1, OFF_IRQ_ENABLE, 1);
    for (int k = 0; k < 3; k++) begin
      xfer(1, OFF_CTRL_B, 0); xfer(1, OFF_COUNTER, 32'hF0);
      xfer(1, OFF_IRQ_CLEAR, 3); xfer(1, OFF_GEN_CTRL, 1);
      xfer(1, OFF_CTRL_B, k + 1);
      c = 0;
      while (irq !== 1'b1 && c < 16 * n[k] + 40) begin
        @(posedge clock);
        c++;
      end
      if (c >= 16 * n[k] + 40) begin
        num_errors++;
        complete_run();
      end
      check(c >= 15 * n[k] - 2 && c <= 16 * n[k] + 8, 1);
    end
    xfer(0, OFF_IRQ_STATUS, 0); check(r[0], 1);
    xfer(1, OFF_IRQ_ENABLE, 0); check(irq, 0);
    xfer(1, OFF_IRQ_ENABLE, 1); check(irq, 1);
    xfer(1, OFF_IRQ_CLEAR, 1); check(irq, 0);
    $display("test prescale done");
  endtask
  task automatic pulses();
    repeat (4) begin
      @(posedge clock);
      xin <= 1'b1;
      @(posedge clock);
      xin <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask
  task automatic t_source();
    xfer(1, OFF_CTRL_B, 0); xfer(1, OFF_CLK_SRC, 1);
    xfer(1, OFF_COUNTER, 0); xfer(1, OFF_CTRL_B, 1);
    repeat (10) @(posedge clock);
    xfer(0, OFF_COUNTER, 0); check(r, 0);
    xfer(1, OFF_CLK_SRC, 3); pulses();
    xfer(0, OFF_COUNTER, 0); check(r, 4);
    xfer(1, OFF_CTRL_B, 0); pulses();
    xfer(0, OFF_COUNTER, 0); check(r, 4);
    xfer(1, OFF_CLK_SRC, 0);
    $display("test source done");
  endtask
  // Main sequence
  initial begin
    req = '0;
    rstn = 1'b0;
    io_tick = 1'b1;
    xtal_tick = 1'b0;
    xin = 1'b0;
    dir = 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_force();
    t_prescale();
    t_source();
    complete_run();
  end
endmodule
`default_nettype wire

// File: dv/tmr_core_properties.sv
// Purpose: Port-level checker for the timer core
// Assumes: Control fields are shadowed from APB writes
// Notes:   Forced strobes are judged only while the counter is stopped
`timescale 1ns/1ps
`default_nettype none
module tmr_core_props #(
  parameter int CNT_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire tmr_pkg::tmr_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pin_dir_out,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe_n,
  input wire logic compare_override,
  input wire logic irq
);
  import tmr_pkg::*;
  logic wr, rd, frc;
  logic [1:0] com_q, wgm_q, en_q;
  logic [2:0] cs_q;
  // Access decode; a stopped counter keeps real matches out of the strobe checks
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en;
  assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign frc = wr && apb_req.paddr == OFF_CTRL_B && apb_req.pwdata[7] && cs_q == 3'h0;
  // Shadow of the fields that steer the checks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      com_q <= 2'h0;
      wgm_q <= 2'h0;
      cs_q <= 3'h0;
      en_q <= 2'h0;
    end else if (wr) begin
      if (apb_req.paddr == OFF_CTRL_A) begin
        com_q <= apb_req.pwdata[7:6];
        wgm_q <= apb_req.pwdata[1:0];
      end
      if (apb_req.paddr == OFF_CTRL_B) cs_q <= apb_req.pwdata[2:0];
      if (apb_req.paddr == OFF_IRQ_ENABLE) en_q <= apb_req.pwdata[1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_override_com: assert property (!(wgm_q[0] && com_q == 2'h1) |->
    compare_override == (com_q != 2'h0)) else $error("override wrong");
  a_pin_driver: assert property (compare_override |->
    compare_output_oe_n == !pin_dir_out) else $error("driver enable wrong");
  a_pwm_disc: assert property (wgm_q[0] && com_q == 2'h1 |-> compare_output_oe_n)
    else $error("pin driven in pwm mode one");
  a_force_toggle: assert property (frc && !wgm_q[0] && com_q == 2'h1 |=>
    compare_output_pin != $past(compare_output_pin)) else $error("no toggle");
  a_force_level: assert property (frc && !wgm_q[0] && com_q[1] |=>
    compare_output_pin == $past(com_q[0])) else $error("forced level wrong");
  a_force_pwm: assert property (frc && wgm_q[0] |=> $stable(compare_output_pin))
    else $error("strobe acted in pwm");
  a_force_noirq: assert property (frc && !irq |=> !irq)
    else $error("strobe raised irq");
  a_strobe_read: assert property (rd && apb_req.paddr == OFF_CTRL_B |=>
    prdata[31:3] == 29'h0) else $error("ctrl b reads ones");
  a_ctrla_rsvd: assert property (rd && apb_req.paddr == OFF_CTRL_A |=>
    prdata[5:2] == 4'h0 && prdata[31:8] == 24'h0) else $error("reserved bits set");
  a_irq_mask: assert property (en_q == 2'h0 |-> !irq)
    else $error("masked irq high");
  c_force: cover property (frc && com_q == 2'h1);
  c_irq: cover property (irq);
  c_drive: cover property (!compare_output_oe_n);
endmodule
bind tmr_core tmr_core_props #(.CNT_W(CNT_W)) u_props (.clock(clock), .rstn(rstn),
  .clk_en(clk_en), .apb_req(apb_req), .prdata(prdata), .pin_dir_out(pin_dir_out),
  .compare_output_pin(compare_output_pin), .compare_output_oe_n(compare_output_oe_n),
  .compare_override(compare_override), .irq(irq));
`default_nettype wire

// File: hdl/tmr_core.sv
// Purpose: 8-bit timer/counter with source select, prescaler, waveform unit and APB registers
// Assumes: Source clocks arrive as synchronous ticks of the bus clock
// Notes:   Pin driver is enabled only while a compare mode is set and direction is output
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Source is the I/O clock unless async select picks crystal or external pin.
// - Async select plus external enable takes the clock from the crystal input pin.
// - Prescaler reset bit clears the prescaler for a predictable phase.
// - Clock select 0 stops, 1 undivided, 2..7 divide by 8,32,64,128,256,1024.
// - Nonzero compare mode overrides the pin except mode 1 in PWM; driver enabled only when direction is output.
// - Non-PWM modes: 0 disconnect, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: 0,1 disconnect; 2 clear on match set at bottom; 3 inverse.
// - Phase correct: 2 clears on up match, sets on down match; 3 opposite.
// - PWM with compare equal to top and upper mode bit: act at top instead.
// - Mode 0 normal, 1 phase correct, 2 CLEAR_ON_MATCH_MODE, 3 fast PWM; top 0xFF except CLEAR_ON_MATCH_MODE.
// - Compare updates immediately in non-PWM, at top in PWM; overflow at MAX or BOTTOM.
// - Force strobe acts only in non-PWM modes; software writes it zero in PWM.
// - Force strobe applies an immediate match using the compare mode bits held.
// - Forced match sets no flag, does not clear in CLEAR_ON_MATCH_MODE, and reads as zero.
// - A counter write blocks the compare match on the next timer tick.
module tmr_core #(
  parameter int CNT_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire tmr_pkg::tmr_apb_req_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic io_tick,
  input wire logic xtal_tick,
  input wire logic crystal_input_pin,
  input wire logic pin_dir_out,
  output logic compare_output_pin,
  output logic compare_output_oe_n,
  output logic compare_override,
  output logic irq
);
  import tmr_pkg::*;

  tmr_state_s q, d;
  tmr_src_e src;
  logic src_tick, cnt_en, pwm, wr, rd, rd_setup, hit, at_top, psr;
  logic pin_prev_q, ext_tick;
  logic [7:0] top, wv;
  logic [PRESCALE_BITS-1:0] pre_nx;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Prescaler tap for a clock select value
  function automatic logic tap_hit(input logic [2:0] sel, input logic [PRESCALE_BITS-1:0] p);
    unique case (sel)
      3'h0: tap_hit = 1'b0;
      3'h1: tap_hit = 1'b1;
      3'h2: tap_hit = (p[2:0] == 3'h7);
      3'h3: tap_hit = (p[4:0] == 5'h1F);
      3'h4: tap_hit = (p[5:0] == 6'h3F);
      3'h5: tap_hit = (p[6:0] == 7'h7F);
      3'h6: tap_hit = (p[7:0] == 8'hFF);
      3'h7: tap_hit = (p == 10'h3FF);
    endcase
  endfunction

  function automatic logic is_pwm(input logic [1:0] w);
    is_pwm = (w == WGM_PC_PWM) || (w == WGM_FAST_PWM);
  endfunction

  // ----------------------------------------
  // Clock source
  // ----------------------------------------
  // Edge of the external pin; pin is taken as synchronous
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_prev_q <= 1'b0;
    end else if (clk_en) begin
      pin_prev_q <= crystal_input_pin;
    end
  end
  assign ext_tick = crystal_input_pin & ~pin_prev_q;

  // Source pick
  always_comb begin
    if (!q.async_sel) begin
      src = TMR_SRC_IO;
    end else if (q.ext_en) begin
      src = TMR_SRC_EXT;
    end else begin
      src = TMR_SRC_XTAL;
    end
  end

  always_comb begin
    unique case (src)
      TMR_SRC_IO: src_tick = io_tick;
      TMR_SRC_XTAL: src_tick = xtal_tick;
      TMR_SRC_EXT: src_tick = ext_tick;
    endcase
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  // Read data is loaded in the setup cycle so it stands when pready is sampled
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign wv = apb_req.pwdata[7:0];
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign psr = wr && (apb_req.paddr == OFF_GEN_CTRL) && wv[GEN_PSR_BIT];

  // Prescaler advances on source ticks; a reset bit write restarts it
  assign pre_nx = psr ? '0 : (src_tick ? q.pre + 1'b1 : q.pre);
  assign cnt_en = src_tick && tap_hit(q.cs, q.pre) && !psr;

  assign pwm = is_pwm(q.wgm);
  assign top = (q.wgm == WGM_CTC) ? q.ocr : VAL_MAX;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One cycle of the counter, waveform and register file.
  // Slave answers every access in one cycle; unmapped addresses flag pslverr.
  always_comb begin
    logic force_cmp;
    logic set_top, cmp_now;
    logic [1:0] ev_set;
    force_cmp = 1'b0;
    ev_set = 2'h0;
    set_top = 1'b0;
    cmp_now = 1'b0;
    hit = 1'b0;
    at_top = 1'b0;
    d = q;
    d.pre = pre_nx;
    pslverr = 1'b0;

    // Counter and waveform unit
    if (cnt_en) begin
      at_top = (q.cnt == top);
      cmp_now = (q.cnt == q.ocr);
      hit = cmp_now && !q.blk_match;
      d.blk_match = 1'b0;
      set_top = pwm && (q.ocr == VAL_MAX) && q.com[1];
      unique case (q.wgm)
        WGM_NORMAL, WGM_CTC: begin
          if (hit) begin
            unique case (q.com)
              2'h0: d.oc = q.oc;
              2'h1: d.oc = ~q.oc;
              2'h2: d.oc = 1'b0;
              2'h3: d.oc = 1'b1;
            endcase
          end
          d.cnt = at_top ? VAL_BOTTOM : q.cnt + 8'h01;
          if (q.cnt == VAL_MAX) begin
            d.irq_stat[IRQ_OVF_BIT] = 1'b1;
          end
        end
        WGM_FAST_PWM: begin
          if (set_top && at_top) begin
            d.oc = (q.com == 2'h3);
          end else if (at_top && q.com[1]) begin
            d.oc = (q.com == 2'h2);
          end else if (hit && !set_top && q.com[1]) begin
            d.oc = (q.com == 2'h3);
          end
          d.cnt = q.cnt + 8'h01;
          if (at_top) begin
            d.ocr = q.ocr_buf;
            d.irq_stat[IRQ_OVF_BIT] = 1'b1;
          end
        end
        WGM_PC_PWM: begin
          if (set_top && at_top) begin
            d.oc = (q.com == 2'h3);
          end else if (hit && !set_top && q.com[1]) begin
            d.oc = q.dir_down ? (q.com == 2'h2) : (q.com == 2'h3);
          end
          if (!q.dir_down) begin
            d.cnt = at_top ? q.cnt - 8'h01 : q.cnt + 8'h01;
            d.dir_down = at_top;
            if (at_top) begin
              d.ocr = q.ocr_buf;
            end
          end else begin
            d.cnt = (q.cnt == VAL_BOTTOM) ? q.cnt + 8'h01 : q.cnt - 8'h01;
            d.dir_down = (q.cnt != VAL_BOTTOM);
            if (q.cnt == VAL_BOTTOM) begin
              d.irq_stat[IRQ_OVF_BIT] = 1'b1;
            end
          end
        end
      endcase
      if (hit) begin
        d.irq_stat[IRQ_CMP_BIT] = 1'b1;
      end
    end
    // Flags raised by this cycle's events, re-applied after a clear
    ev_set = d.irq_stat & ~q.irq_stat;

    // Register writes; clear applies before events so a set wins
    if (wr) begin
      unique case (apb_req.paddr)
        OFF_CTRL_A: begin
          d.com = wv[CTRLA_COM_LSB +: 2];
          d.wgm = wv[1:0];
        end
        OFF_CTRL_B: begin
          d.cs = wv[2:0];
          force_cmp = wv[CTRLB_FORCE_BIT] && !pwm;
        end
        OFF_GEN_CTRL: d.pre = '0;
        OFF_CLK_SRC: begin
          d.async_sel = wv[SRC_ASYNC_BIT];
          d.ext_en = wv[SRC_EXT_BIT];
        end
        OFF_COUNTER: begin
          d.cnt = wv;
          d.blk_match = 1'b1;
        end
        OFF_COMPARE: begin
          d.ocr_buf = wv;
          if (!pwm) begin
            d.ocr = wv;
          end
        end
        OFF_IRQ_CLEAR: d.irq_stat = q.irq_stat & ~wv[1:0];
        OFF_IRQ_ENABLE: d.irq_en = wv[1:0];
        OFF_IRQ_STATUS: ;
        default: pslverr = 1'b1;
      endcase
    end
    // Same-cycle event beats a software clear
    d.irq_stat = d.irq_stat | ev_set;

    // Forced match: pin only, no flag and no counter clear
    if (force_cmp) begin
      unique case (q.com)
        2'h0: d.oc = q.oc;
        2'h1: d.oc = ~q.oc;
        2'h2: d.oc = 1'b0;
        2'h3: d.oc = 1'b1;
      endcase
    end

    // Read data; strobe and reserved bits return zero
    if (rd_setup || rd) begin
      unique case (apb_req.paddr)
        OFF_CTRL_A: d.prdata = {24'h0, q.com, 4'h0, q.wgm};
        OFF_CTRL_B: d.prdata = {29'h0, q.cs};
        OFF_GEN_CTRL: d.prdata = 32'h0;
        OFF_CLK_SRC: d.prdata = {30'h0, q.ext_en, q.async_sel};
        OFF_COUNTER: d.prdata = {24'h0, q.cnt};
        OFF_COMPARE: d.prdata = {24'h0, q.ocr_buf};
        OFF_IRQ_STATUS: d.prdata = {30'h0, q.irq_stat};
        OFF_IRQ_CLEAR: d.prdata = 32'h0;
        OFF_IRQ_ENABLE: d.prdata = {30'h0, q.irq_en};
        default: begin
          d.prdata = 32'h0;
          pslverr = rd;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes everything
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign compare_override = (q.com != 2'h0) && !(pwm && q.com == 2'h1);
  assign compare_output_pin = q.oc;
  assign compare_output_oe_n = ~(compare_override & pin_dir_out);
  assign irq = |(q.irq_stat & q.irq_en);

endmodule
`default_nettype wire

// File: hdl/tmr_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer with prescaler and waveform control
// Assumes: APB register access, 32-bit data, one word per register
// Notes:   Offsets, reset values and field positions live here only
package tmr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_GEN_CTRL = 8'h08;
  localparam logic [7:0] OFF_CLK_SRC = 8'h0C;
  localparam logic [7:0] OFF_COUNTER = 8'h10;
  localparam logic [7:0] OFF_COMPARE = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRLA_COM_LSB = 6;
  localparam int CTRLB_FORCE_BIT = 7;
  localparam int GEN_PSR_BIT = 0;
  localparam int SRC_ASYNC_BIT = 0;
  localparam int SRC_EXT_BIT = 1;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VAL_MAX = 8'hFF;
  localparam logic [7:0] VAL_BOTTOM = 8'h00;
  localparam int PRESCALE_BITS = 10;

  // Waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PC_PWM = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;

  // Timer source selection
  typedef enum logic [1:0] {
    TMR_SRC_IO,
    TMR_SRC_XTAL,
    TMR_SRC_EXT
  } tmr_src_e;

  // APB request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tmr_apb_req_s;

  // All block state except the external pin edge register
  typedef struct packed {
    logic [1:0] com;
    logic [1:0] wgm;
    logic [2:0] cs;
    logic async_sel;
    logic ext_en;
    logic [7:0] cnt;
    logic [7:0] ocr_buf;
    logic [7:0] ocr;
    logic dir_down;
    logic blk_match;
    logic oc;
    logic [PRESCALE_BITS-1:0] pre;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] prdata;
  } tmr_state_s;

endpackage
